//--- design/fpioc_top.sv
`timescale 1ns/10ps

// Overview of operation
// - only full 32-bit register accesses are honoured
// - decode eight locations plus optional auxiliary one
// - input register reads the 32 input lines
// - output register drives lines, reads back value
// - input acknowledge after read or store, if enabled
// - request edge latches input when enabled
// - timer 0 falling edge samples input
// - input FIFO enable queues each sample unless the queue is full
// - trigger edge of chosen polarity starts sampling
// - input enable low halts sampling and disarms the trigger
// - output request waits for acknowledge before next
// - output request strobe on each new word
// - timer 1 low edge moves next output word
// - output FIFO enable sources words from FIFO
// - software trigger pin follows its control bit
// - sticky overrun on sample into full FIFO
// - sticky underrun on request from empty FIFO
// - five interrupt sources, each individually enabled
// - interrupt status set on event, write-one clears
// - cascade bits select timer 2 as clock
// - request polarity bit picks latching edge
// - on-board queue clear, empty and full flags
// - acknowledge held while the request line stays high
// - output request re-asserted only after acknowledge
module fpioc_top
    import fpioc_pkg::*;
#(
    parameter int HAS_AUX = 1,
    parameter int AUX_W = 4
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic [5:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [3:0] REG_BE,
    input wire logic [31:0] REG_WDATA,
    output logic [31:0] REG_RDATA,
    output logic [1:0] TMR_ADDR,
    output logic TMR_WR,
    output logic TMR_RD,
    output logic [31:0] TMR_WDATA,
    input wire logic [31:0] TMR_RDATA,
    output logic TMR0_CHAIN,
    output logic TMR1_CHAIN,
    input wire logic TMR0_OUT,
    input wire logic TMR1_OUT,
    input wire logic TMR2_OUT,
    input wire logic [31:0] DIN_LINES,
    input wire logic IN_REQ,
    input wire logic IN_START,
    output logic IN_ACK,
    output logic [31:0] DOUT_LINES,
    output logic OUT_REQ,
    input wire logic OUT_ACK,
    output logic SW_TRIG,
    output logic IN_VALID,
    input wire logic IN_READY,
    output logic [31:0] IN_DATA,
    input wire logic OUT_VALID,
    output logic OUT_READY,
    input wire logic [31:0] OUT_DATA,
    input wire logic [AUX_W-1:0] AUX_IN,
    output logic [AUX_W-1:0] AUX_OUT,
    output logic IRQ
);

    function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
        hit = (a == ofs);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [31:0] di_s1_r, di_s2_r;
    logic [AUX_W-1:0] aux_s1_r, aux_s2_r;
    logic [FPIOC_S_N-1:0] pin_s1_r, pin_s2_r, pin_prev_r;
    logic [FPIOC_S_N-1:0] pin_raw;

    assign pin_raw = {TMR2_OUT, TMR1_OUT, TMR0_OUT, OUT_ACK, IN_START, IN_REQ};

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            di_s1_r <= FPIOC_RST_WORD;
            di_s2_r <= FPIOC_RST_WORD;
            aux_s1_r <= '0;
            aux_s2_r <= '0;
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            pin_prev_r <= '0;
        end else begin
            di_s1_r <= DIN_LINES;
            di_s2_r <= di_s1_r;
            aux_s1_r <= AUX_IN;
            aux_s2_r <= aux_s1_r;
            pin_s1_r <= pin_raw;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    logic [FPIOC_S_N-1:0] rise, fall;
    assign rise = pin_s2_r & ~pin_prev_r;
    assign fall = ~pin_s2_r & pin_prev_r;

    ////////////////////////////////////////////////////////////////////
    // state

    fpioc_pctl_t pctl_r, pctl_nxt;
    fpioc_ictl_t ictl_r, ictl_nxt;
    logic [FPIOC_I_NSRC-1:0] flag_r, flag_nxt;
    logic ovr_r, ovr_nxt, und_r, und_nxt;
    logic armed_r, armed_nxt, ack_r, ack_nxt;
    logic [31:0] do_r, do_nxt, rdata_r, rdata_nxt;
    logic [AUX_W-1:0] aux_r, aux_nxt;
    logic [31:0] buf_r [2];
    logic [31:0] buf_nxt [2];
    logic wp_r, wp_nxt, rp_r, rp_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    fpioc_ostate_t ost_r, ost_nxt;
    logic oreq_r, oreq_nxt, irq_r, irq_nxt;

    logic wr_ok, rd_ok, trg_edge, req_edge, sample, push, pop, stored;
    logic pace, load, host_do, ready_evt, din_rd, qclr, underrun_evt;
    logic [FPIOC_I_NSRC-1:0] src;

    // partial-width accesses are dropped; no byte-lane merge exists
    assign wr_ok = REG_WR && (REG_BE == FPIOC_BE_FULL);
    assign rd_ok = REG_RD && (REG_BE == FPIOC_BE_FULL);

    // timer block lives outside; its three counters pass through, its control word on writes only
    assign TMR_ADDR = REG_ADDR[3:2];
    assign TMR_WR = wr_ok && (REG_ADDR[5:4] == 2'b00);
    assign TMR_RD = rd_ok && (REG_ADDR[5:4] == 2'b00) && !hit(REG_ADDR, FPIOC_OFS_TMRCW);
    assign TMR_WDATA = REG_WDATA;
    assign TMR0_CHAIN = ictl_r.chain0;
    assign TMR1_CHAIN = ictl_r.chain1;

    always_comb begin
        pctl_nxt = pctl_r;
        ictl_nxt = ictl_r;
        do_nxt = do_r;
        aux_nxt = aux_r;
        buf_nxt = buf_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        rdata_nxt = rdata_r;

        // input sampling
        trg_edge = pctl_r.start_pol ? rise[FPIOC_S_ITRG] : fall[FPIOC_S_ITRG];
        req_edge = ictl_r.req_pol ? fall[FPIOC_S_IREQ] : rise[FPIOC_S_IREQ];
        if (!pctl_r.din_en) begin
            armed_nxt = 1'b0;
        end else if (!pctl_r.trig_en || trg_edge) begin
            armed_nxt = 1'b1;
        end else begin
            armed_nxt = armed_r;
        end
        sample = pctl_r.din_en && armed_r
            && ((pctl_r.in_timer_en && fall[FPIOC_S_T0])
            || (pctl_r.in_req_en && req_edge));
        push = sample && pctl_r.in_fifo_en;
        qclr = wr_ok && hit(REG_ADDR, FPIOC_OFS_ICTL) && REG_WDATA[FPIOC_I_QCLR];
        pop = IN_READY && (cnt_r != 2'd0);
        stored = push && (cnt_r != 2'd2);

        // two-entry queue toward the bus-master side
        if (qclr) begin
            // a push in the same cycle still lands in the emptied queue, unless the queue was full
            wp_nxt = 1'b0;
            rp_nxt = 1'b0;
            cnt_nxt = stored ? 2'd1 : 2'd0;
            if (stored) begin
                buf_nxt[0] = di_s2_r;
                wp_nxt = 1'b1;
            end
        end else begin
            if (stored) begin
                buf_nxt[wp_r] = di_s2_r;
                wp_nxt = ~wp_r;
            end
            if (pop) begin
                rp_nxt = ~rp_r;
            end
            cnt_nxt = 2'(cnt_r + {1'b0, stored} - {1'b0, pop});
        end

        din_rd = rd_ok && hit(REG_ADDR, FPIOC_OFS_DIN);
        // ack raised by a store or a host read, held while request stays up
        ack_nxt = pctl_r.in_ack_en
            && ((ack_r && pin_s2_r[FPIOC_S_IREQ]) || stored || din_rd);

        // output side
        pace = pctl_r.out_timer_en ? fall[FPIOC_S_T1] : 1'b1;
        OUT_READY = pctl_r.out_fifo_en && pace && (ost_r == FPIOC_O_IDLE);
        load = OUT_READY && OUT_VALID;
        // only timer pacing counts as a demand; free-running mode just idles
        underrun_evt = OUT_READY && pctl_r.out_timer_en && !OUT_VALID;
        host_do = wr_ok && hit(REG_ADDR, FPIOC_OFS_DOUT) && !pctl_r.out_fifo_en;
        if (load) begin
            do_nxt = OUT_DATA;
        end else if (host_do) begin
            do_nxt = REG_WDATA;
        end
        ready_evt = load || host_do;

        ost_nxt = ost_r;
        unique case (ost_r)
            FPIOC_O_IDLE: begin
                if (ready_evt && pctl_r.out_req_en && pctl_r.out_ack_en) begin
                    ost_nxt = FPIOC_O_WAIT;
                end
            end
            FPIOC_O_WAIT: begin
                // a fresh edge only: the previous word's ack may still be high
                if (rise[FPIOC_S_OACK] || !pctl_r.out_ack_en) begin
                    ost_nxt = FPIOC_O_IDLE;
                end
            end
        endcase
        oreq_nxt = (ost_nxt == FPIOC_O_WAIT)
            || ((ost_r == FPIOC_O_IDLE) && ready_evt && pctl_r.out_req_en
            && !pctl_r.out_ack_en);

        // interrupt sources and sticky flags; set wins over clear
        src = '0;
        src[FPIOC_SRC_OACK] = rise[FPIOC_S_OACK];
        src[FPIOC_SRC_IREQ] = req_edge;
        src[FPIOC_SRC_T0] = rise[FPIOC_S_T0];
        src[FPIOC_SRC_T1] = rise[FPIOC_S_T1];
        src[FPIOC_SRC_T2] = rise[FPIOC_S_T2];
        flag_nxt = flag_r;
        ovr_nxt = ovr_r;
        und_nxt = und_r;
        if (wr_ok && hit(REG_ADDR, FPIOC_OFS_ICTL)) begin
            flag_nxt = flag_r & ~REG_WDATA[FPIOC_I_FLAG_LSB +: FPIOC_I_NSRC];
        end
        if (wr_ok && hit(REG_ADDR, FPIOC_OFS_PCTL)) begin
            ovr_nxt = ovr_r && !REG_WDATA[FPIOC_P_OVR];
            und_nxt = und_r && !REG_WDATA[FPIOC_P_UND];
        end
        flag_nxt = flag_nxt | (src & ictl_r.irq_en);
        ovr_nxt = ovr_nxt || (push && (cnt_r == 2'd2));
        und_nxt = und_nxt || underrun_evt;

        // control writes
        if (wr_ok && hit(REG_ADDR, FPIOC_OFS_PCTL)) begin
            pctl_nxt = fpioc_pctl_t'(REG_WDATA[FPIOC_P_SW_TRIG:0]);
        end
        if (wr_ok && hit(REG_ADDR, FPIOC_OFS_ICTL)) begin
            ictl_nxt.irq_en = REG_WDATA[FPIOC_I_EN_LSB +: FPIOC_I_NSRC];
            ictl_nxt.chain0 = REG_WDATA[FPIOC_I_CHAIN0];
            ictl_nxt.chain1 = REG_WDATA[FPIOC_I_CHAIN1];
            ictl_nxt.req_pol = REG_WDATA[FPIOC_I_REQ_POL];
        end
        irq_nxt = |(flag_nxt & ictl_nxt.irq_en);
        if (HAS_AUX != 0 && wr_ok && hit(REG_ADDR, FPIOC_OFS_AUX)) begin
            aux_nxt = REG_WDATA[AUX_W-1:0];
        end

        // read mux; unmapped reads return zero, partial reads keep the last read data
        if (rd_ok) begin
            rdata_nxt = FPIOC_RST_WORD;
            unique case (REG_ADDR)
                FPIOC_OFS_TMR0, FPIOC_OFS_TMR1, FPIOC_OFS_TMR2: rdata_nxt = TMR_RDATA;
                FPIOC_OFS_DIN: rdata_nxt = di_s2_r;
                FPIOC_OFS_DOUT: rdata_nxt = do_r;
                FPIOC_OFS_PCTL: begin
                    rdata_nxt[FPIOC_P_SW_TRIG:0] = pctl_r;
                    rdata_nxt[FPIOC_P_OVR] = ovr_r;
                    rdata_nxt[FPIOC_P_UND] = und_r;
                end
                FPIOC_OFS_ICTL: begin
                    rdata_nxt[FPIOC_I_EN_LSB +: FPIOC_I_NSRC] = ictl_r.irq_en;
                    rdata_nxt[FPIOC_I_FLAG_LSB +: FPIOC_I_NSRC] = flag_r;
                    rdata_nxt[FPIOC_I_CHAIN0] = ictl_r.chain0;
                    rdata_nxt[FPIOC_I_CHAIN1] = ictl_r.chain1;
                    rdata_nxt[FPIOC_I_REQ_POL] = ictl_r.req_pol;
                    rdata_nxt[FPIOC_I_QEMPTY] = (cnt_r == 2'd0);
                    rdata_nxt[FPIOC_I_QFULL] = (cnt_r == 2'd2);
                end
                FPIOC_OFS_AUX: begin
                    if (HAS_AUX != 0) begin
                        rdata_nxt[AUX_W-1:0] = aux_s2_r;
                    end
                end
                default: rdata_nxt = FPIOC_RST_WORD;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pctl_r <= FPIOC_PCTL_RST;
            ictl_r <= FPIOC_ICTL_RST;
            flag_r <= '0;
            ovr_r <= 1'b0;
            und_r <= 1'b0;
            armed_r <= 1'b0;
            ack_r <= 1'b0;
            do_r <= FPIOC_RST_WORD;
            rdata_r <= FPIOC_RST_WORD;
            aux_r <= '0;
            buf_r[0] <= FPIOC_RST_WORD;
            buf_r[1] <= FPIOC_RST_WORD;
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'd0;
            ost_r <= FPIOC_O_IDLE;
            oreq_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            pctl_r <= pctl_nxt;
            ictl_r <= ictl_nxt;
            flag_r <= flag_nxt;
            ovr_r <= ovr_nxt;
            und_r <= und_nxt;
            armed_r <= armed_nxt;
            ack_r <= ack_nxt;
            do_r <= do_nxt;
            rdata_r <= rdata_nxt;
            aux_r <= aux_nxt;
            buf_r <= buf_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            ost_r <= ost_nxt;
            oreq_r <= oreq_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign DOUT_LINES = do_r;
    assign SW_TRIG = pctl_r.sw_trig;
    assign IN_ACK = ack_r;
    assign OUT_REQ = oreq_r;
    assign IRQ = irq_r;
    assign AUX_OUT = aux_r;
    assign IN_VALID = (cnt_r != 2'd0);
    assign IN_DATA = buf_r[rp_r];

    ////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);

    property p_partial_ignored;
        REG_WR && REG_BE != FPIOC_BE_FULL |=> pctl_r == $past(pctl_r);
    endproperty
    a_partial_ignored: assert property (p_partial_ignored)
        else $error("partial write changed port control");

    property p_dout_write;
        wr_ok && hit(REG_ADDR, FPIOC_OFS_DOUT) && !pctl_r.out_fifo_en
            |=> DOUT_LINES == $past(REG_WDATA);
    endproperty
    a_dout_write: assert property (p_dout_write)
        else $error("output lines do not follow host write");

    property p_din_read;
        rd_ok && hit(REG_ADDR, FPIOC_OFS_DIN) |=> REG_RDATA == $past(di_s2_r);
    endproperty
    a_din_read: assert property (p_din_read)
        else $error("input read does not return input lines");

    property p_ack_off;
        !pctl_r.in_ack_en |=> !IN_ACK;
    endproperty
    a_ack_off: assert property (p_ack_off)
        else $error("input ack asserted while disabled");

    property p_ack_hold;
        IN_ACK && pin_s2_r[FPIOC_S_IREQ] && pctl_r.in_ack_en |=> IN_ACK;
    endproperty
    a_ack_hold: assert property (p_ack_hold)
        else $error("input ack dropped before request release");

    property p_sw_trig;
        wr_ok && hit(REG_ADDR, FPIOC_OFS_PCTL) |=> SW_TRIG == $past(REG_WDATA[FPIOC_P_SW_TRIG]);
    endproperty
    a_sw_trig: assert property (p_sw_trig)
        else $error("software trigger pin does not follow bit");

    property p_halt;
        !pctl_r.din_en |-> !sample ##1 !armed_r;
    endproperty
    a_halt: assert property (p_halt)
        else $error("input activity while input disabled");

    property p_overrun;
        push && cnt_r == 2'd2 |=> ovr_r;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not flagged on full queue");

    property p_underrun;
        underrun_evt |=> und_r;
    endproperty
    a_underrun: assert property (p_underrun)
        else $error("underrun not flagged");

    property p_oreq_hold;
        OUT_REQ && pctl_r.out_ack_en && !pin_s2_r[FPIOC_S_OACK] |=> OUT_REQ;
    endproperty
    a_oreq_hold: assert property (p_oreq_hold)
        else $error("output request dropped before acknowledge");

    property p_irq;
        ##1 IRQ == |(flag_r & ictl_r.irq_en);
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt line disagrees with enabled flags");

    c_handshake_in: cover property (stored ##[1:8] IN_ACK ##[1:20] !IN_ACK);
    c_overrun: cover property (!ovr_r ##1 ovr_r);
    c_out_wait: cover property (OUT_REQ ##[1:20] !OUT_REQ && ost_r == FPIOC_O_IDLE);
    c_irq: cover property (!IRQ ##1 IRQ);

endmodule

//--- design/fpioc_pkg.sv
package fpioc_pkg;

    // register byte offsets
    localparam logic [5:0] FPIOC_OFS_TMR0 = 6'h00;
    localparam logic [5:0] FPIOC_OFS_TMR1 = 6'h04;
    localparam logic [5:0] FPIOC_OFS_TMR2 = 6'h08;
    localparam logic [5:0] FPIOC_OFS_TMRCW = 6'h0C;
    localparam logic [5:0] FPIOC_OFS_DIN = 6'h10;
    localparam logic [5:0] FPIOC_OFS_DOUT = 6'h14;
    localparam logic [5:0] FPIOC_OFS_PCTL = 6'h18;
    localparam logic [5:0] FPIOC_OFS_ICTL = 6'h1C;
    localparam logic [5:0] FPIOC_OFS_AUX = 6'h20;
    localparam logic [3:0] FPIOC_BE_FULL = 4'hF;

    // port_mode_and_status fields
    localparam int FPIOC_P_IN_ACK = 0;
    localparam int FPIOC_P_IN_REQ = 1;
    localparam int FPIOC_P_IN_TMR = 2;
    localparam int FPIOC_P_IN_FIFO = 3;
    localparam int FPIOC_P_START_POL = 4;
    localparam int FPIOC_P_TRIG_EN = 5;
    localparam int FPIOC_P_DIN_EN = 6;
    localparam int FPIOC_P_OUT_ACK = 7;
    localparam int FPIOC_P_OUT_REQ = 8;
    localparam int FPIOC_P_OUT_TMR = 9;
    localparam int FPIOC_P_OUT_FIFO = 10;
    localparam int FPIOC_P_SW_TRIG = 11;
    localparam int FPIOC_P_OVR = 14;
    localparam int FPIOC_P_UND = 16;

    // irq_mode_and_status fields
    localparam int FPIOC_I_EN_LSB = 0;
    localparam int FPIOC_I_FLAG_LSB = 5;
    localparam int FPIOC_I_NSRC = 5;
    localparam int FPIOC_I_CHAIN0 = 10;
    localparam int FPIOC_I_CHAIN1 = 11;
    localparam int FPIOC_I_REQ_POL = 12;
    localparam int FPIOC_I_QCLR = 13;
    localparam int FPIOC_I_QEMPTY = 14;
    localparam int FPIOC_I_QFULL = 15;

    // interrupt source order: out ack, in request, timer 0, 1, 2
    localparam int FPIOC_SRC_OACK = 0;
    localparam int FPIOC_SRC_IREQ = 1;
    localparam int FPIOC_SRC_T0 = 2;
    localparam int FPIOC_SRC_T1 = 3;
    localparam int FPIOC_SRC_T2 = 4;

    // synchronised single-bit pins
    localparam int FPIOC_S_IREQ = 0;
    localparam int FPIOC_S_ITRG = 1;
    localparam int FPIOC_S_OACK = 2;
    localparam int FPIOC_S_T0 = 3;
    localparam int FPIOC_S_T1 = 4;
    localparam int FPIOC_S_T2 = 5;
    localparam int FPIOC_S_N = 6;

    localparam logic [31:0] FPIOC_RST_WORD = 32'h0000_0000;

    typedef struct packed {
        logic sw_trig;
        logic out_fifo_en;
        logic out_timer_en;
        logic out_req_en;
        logic out_ack_en;
        logic din_en;
        logic trig_en;
        logic start_pol;
        logic in_fifo_en;
        logic in_timer_en;
        logic in_req_en;
        logic in_ack_en;
    } fpioc_pctl_t;

    typedef struct packed {
        logic req_pol;
        logic chain1;
        logic chain0;
        logic [FPIOC_I_NSRC-1:0] irq_en;
    } fpioc_ictl_t;

    localparam fpioc_pctl_t FPIOC_PCTL_RST = '0;
    localparam fpioc_ictl_t FPIOC_ICTL_RST = '0;

    typedef enum logic [0:0] {FPIOC_O_IDLE, FPIOC_O_WAIT} fpioc_ostate_t;

endpackage

//--- testbench/fpioc_ext_dev.sv
`timescale 1ns/10ps
module fpioc_ext_dev (
    input wire logic clk,
    input wire logic in_ack,
    input wire logic out_req,
    output logic [31:0] din_lines,
    output logic in_req,
    output logic out_ack
);
    int ack_dly = 4;
    int n_acks = 0;
    int cnt = 0;
    initial begin
        din_lines = 32'h0;
        in_req = 1'b0;
        out_ack = 1'b0;
    end
    // data settles before the strobe so the sampled word is clean
    task automatic send_word(input logic [31:0] w);
        int n;
        n = 0;
        @(posedge clk);
        din_lines <= w;
        repeat (3) @(posedge clk);
        in_req <= 1'b1;
        while (in_ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        in_req <= 1'b0;
        din_lines <= ~w; // released lines never show the stale word
    endtask
    always @(posedge clk) begin
        if (out_req !== 1'b1) begin
            out_ack <= 1'b0;
            cnt <= 0;
        end else if (cnt >= ack_dly) begin
            if (!out_ack) n_acks <= n_acks + 1;
            out_ack <= 1'b1;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import fpioc_pkg::*;
    typedef struct {
        logic [5:0] a;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [2:0] pins;
    } fpioc_row_t;
    logic CLK, RESETN, REG_WR, REG_RD, TMR0_OUT, TMR1_OUT, IN_READY, OUT_VALID;
    logic [5:0] REG_ADDR;
    logic [3:0] REG_BE, AUX_W;
    logic [31:0] REG_WDATA, REG_RDATA, DIN_LINES, DOUT_LINES, IN_DATA, OUT_DATA, v;
    logic IN_REQ, IN_ACK, OUT_REQ, OUT_ACK, SW_TRIG, IN_VALID, OUT_READY, IRQ, C0, C1;
    logic TMR2_OUT, IN_START;
    int err_count = 0;
    int n_tests = 0;
    int n;
    fpioc_row_t rows[8] = '{
        '{6'h14, 32'hA5A5_5A5A, 32'hA5A5_5A5A, 3'b000},
        '{6'h18, 32'h0000_0800, 32'h0000_0800, 3'b100},
        '{6'h18, 32'h0000_0000, 32'h0000_0000, 3'b000},
        '{6'h1C, 32'h0000_0C00, 32'h0000_4C00, 3'b011},
        '{6'h1C, 32'h0000_1000, 32'h0000_5000, 3'b000},
        '{6'h1C, 32'h0000_0000, 32'h0000_4000, 3'b000},
        '{6'h0C, 32'h0000_1234, 32'h0000_0000, 3'b000},
        '{6'h24, 32'hFFFF_FFFF, 32'h0000_0000, 3'b000}};
    fpioc_top #(.HAS_AUX(1), .AUX_W(4)) fpioc_top_i (.CLK(CLK), .RESETN(RESETN),
        .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_BE(REG_BE),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TMR_ADDR(), .TMR_WR(), .TMR_RD(),
        .TMR_WDATA(), .TMR_RDATA(32'h0), .TMR0_CHAIN(C0), .TMR1_CHAIN(C1),
        .TMR0_OUT(TMR0_OUT), .TMR1_OUT(TMR1_OUT), .TMR2_OUT(TMR2_OUT), .DIN_LINES(DIN_LINES),
        .IN_REQ(IN_REQ), .IN_START(IN_START), .IN_ACK(IN_ACK), .DOUT_LINES(DOUT_LINES),
        .OUT_REQ(OUT_REQ), .OUT_ACK(OUT_ACK), .SW_TRIG(SW_TRIG), .IN_VALID(IN_VALID),
        .IN_READY(IN_READY), .IN_DATA(IN_DATA), .OUT_VALID(OUT_VALID),
        .OUT_READY(OUT_READY), .OUT_DATA(OUT_DATA), .AUX_IN(AUX_W), .AUX_OUT(AUX_W),
        .IRQ(IRQ));
    fpioc_ext_dev fpioc_ext_dev_i (.clk(CLK), .in_ack(IN_ACK), .out_req(OUT_REQ),
        .din_lines(DIN_LINES), .in_req(IN_REQ), .out_ack(OUT_ACK));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_BE <= be;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_BE <= 4'hF;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 chk("reg read", REG_RDATA, exp);
    endtask
    task automatic pulse(input int t);
        @(posedge CLK);
        if (t == 0) TMR0_OUT <= 1'b1; else TMR1_OUT <= 1'b1;
        repeat (4) @(posedge CLK);
        if (t == 0) TMR0_OUT <= 1'b0; else TMR1_OUT <= 1'b0;
        repeat (6) @(posedge CLK);
    endtask
    // hold the word until taken: a stall on the far side must not lose it
    task automatic put_out(input logic [31:0] w);
        n = 0;
        @(posedge CLK);
        OUT_VALID <= 1'b1;
        OUT_DATA <= w;
        #1;
        while (OUT_READY !== 1'b1 && n < 100) begin
            @(posedge CLK);
            #1 n++;
        end
        @(posedge CLK);
        OUT_VALID <= 1'b0;
        n = 0;
        while (OUT_REQ !== 1'b1 && n < 50) begin
            @(posedge CLK);
            #1 n++;
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        {RESETN, REG_WR, REG_RD, TMR0_OUT, TMR1_OUT, IN_READY, OUT_VALID} = '0;
        {TMR2_OUT, IN_START} = '0;
        {REG_ADDR, REG_BE, REG_WDATA, OUT_DATA} = '0;
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        chk("idle pins", {OUT_REQ, IRQ, SW_TRIG, IN_ACK}, 32'h0);
        rchk(6'h18, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i].a, rows[i].wd);
            repeat (3) @(posedge CLK);
            rchk(rows[i].a, rows[i].rd);
            chk("pins", {SW_TRIG, C1, C0}, rows[i].pins);
            chk("dout", DOUT_LINES, 32'hA5A5_5A5A);
        end
        wr(6'h20, 32'h0000_000A);
        repeat (4) @(posedge CLK);
        rchk(6'h20, 32'h0000_000A);
        wr(6'h14, 32'h0, 4'h3);
        rchk(6'h14, 32'hA5A5_5A5A);
        wr(6'h18, 32'h0000_004B);
        fpioc_ext_dev_i.send_word(32'h1357_9BDF);
        #1 chk("queued", {IN_VALID, IN_DATA[30:0]}, 32'h9357_9BDF);
        fpioc_ext_dev_i.send_word(32'h2468_ACE0);
        rchk(6'h1C, 32'h0000_8000);
        rchk(6'h10, 32'hDB97_531F);
        wr(6'h18, 32'h0000_004C);
        pulse(0);
        rchk(6'h18, 32'h0000_404C);
        rchk(6'h1C, 32'h0000_8000);
        wr(6'h18, 32'h0000_4000);
        rchk(6'h18, 32'h0);
        @(posedge CLK);
        IN_READY <= 1'b1;
        @(posedge CLK);
        IN_READY <= 1'b0;
        #1 chk("pop", IN_DATA, 32'h2468_ACE0);
        wr(6'h1C, 32'h0000_2000);
        rchk(6'h1C, 32'h0000_4000);
        wr(6'h1C, 32'h0000_0004);
        pulse(0);
        chk("irq set", IRQ, 1'b1);
        rchk(6'h1C, 32'h0000_4084);
        wr(6'h1C, 32'h0000_0084);
        repeat (3) @(posedge CLK);
        chk("irq clr", IRQ, 1'b0);
        rchk(6'h1C, 32'h0000_4004);
        fpioc_ext_dev_i.ack_dly = 6;
        wr(6'h18, 32'h0000_0580);
        put_out(32'hC0DE_0001);
        chk("word 1", DOUT_LINES, 32'hC0DE_0001);
        put_out(32'hC0DE_0002);
        chk("acks", fpioc_ext_dev_i.n_acks, 1);
        chk("word 2", DOUT_LINES, 32'hC0DE_0002);
        wr(6'h18, 32'h0000_0600);
        pulse(1);
        rchk(6'h18, 32'h0001_0600);
        wr(6'h18, 32'h0001_0000);
        rchk(6'h18, 32'h0);
        wr(6'h18, 32'h0000_007C);
        pulse(0);
        rchk(6'h1C, 32'h0000_4084);
        @(posedge CLK);
        IN_START <= 1'b1;
        pulse(0);
        rchk(6'h1C, 32'h0000_0084);
        report_and_stop();
    end
endmodule
